// File: irq_seq_pkg.sv
/*
 * constants for the interrupt entry and return sequencer.
 * assumes a byte-wide memory port shared with the core, answering in the cycle after a request.
 */
package irq_seq_pkg;
   localparam int          ADDR_W        = 16;
   localparam int          NUM_SRC       = 40;
   localparam int          VEC_W         = 6;
   localparam logic [15:0] VEC_TOP       = 16'hfffe;
   localparam int          QUEUE_BYTES   = 3;
   localparam int          FLAGS_MASK_BIT = 3;
   localparam logic [7:0]  FLAGS_RESET   = 8'h08;
   localparam logic [15:0] SP_RESET      = 16'h00ff;
   localparam logic [15:0] PC_RESET      = 16'h0000;

   typedef enum logic [3:0] {
      ST_RUN     = 4'h0,
      ST_PUSH    = 4'h1,
      ST_VECHI   = 4'h2,
      ST_VECLO   = 4'h3,
      ST_FILL    = 4'h4,
      ST_POP     = 4'h5
   } seq_state_t;

   // stack order: pcl, pch, x, a, flags
   localparam logic [2:0] FRAME_BYTES = 3'h5;
   // read data is taken two cycles after the state that asks for it: strobe flop, then memory
   localparam logic [2:0] RD_LAT      = 3'h2;
endpackage : irq_seq_pkg

// File: irq_entry_exit.sv
/*
 * cpu interrupt entry and exit sequencer: stacking, vector fetch, queue refill, return.
 * assumes the core raises instrDone at each instruction boundary and holds its registers
 * while busy is high; memory is a single byte port with a one-cycle read answer.
 */
// Operation
// - respond only if enabled and mask clear
// - mask flag set after reset
// - finish current instruction before entry
// - hardware entry reuses software trap sequence
// - push registers, then set mask flag
// - fetch vector of highest pending source
// - refill queue with three bytes from vector
// - mask set on entry, cleared by restore
// - return restores flags, a, x, pc
// - index upper byte is never stacked
// - highest priority served first after unmask
// - stack pcl first, flags last
// - sp ends one below stored flags
// - stacked pc is next instruction address
// - pop in reverse, refill three bytes
// - new request during routine stays pending
// - debug module may cause software trap
// - vector high byte first, low next
// - lower vector number wins priority
`timescale 1ns/100ps
module irq_entry_exit
   import irq_seq_pkg::*;
#(
   parameter int NSRC = NUM_SRC
) (
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   input  wire logic [NSRC-1:0]     srcFlag,
   input  wire logic [NSRC-1:0]     srcEnable,
   input  wire logic                instrDone,
   input  wire logic [ADDR_W-1:0]   nextPc,
   input  wire logic [7:0]          accIn,
   input  wire logic [7:0]          idxLowIn,
   input  wire logic                trapOp,
   input  wire logic                debugTrap,
   input  wire logic                returnOp,
   input  wire logic                flagsWrEn,
   input  wire logic [7:0]          flagsWrData,
   input  wire logic                spWrEn,
   input  wire logic [ADDR_W-1:0]   spWrData,
   input  wire logic [7:0]          memRdData,
   output logic                     busy,
   output logic                     memRd,
   output logic                     memWr,
   output logic [ADDR_W-1:0]        memAddr,
   output logic [7:0]               memWrData,
   output logic [7:0]               flagsOut,
   output logic [ADDR_W-1:0]        spOut,
   output logic [ADDR_W-1:0]        pcOut,
   output logic [7:0]               accOut,
   output logic [7:0]               idxLowOut,
   output logic                     restoreDone,
   output logic [VEC_W-1:0]         servedVec,
   output logic [7:0]               queueByte,
   output logic                     queueValid
);

   initial begin
      if (NSRC < 1 || NSRC >= (1 << VEC_W)) $error("NSRC out of range");
   end

   // ----------------------------------------------------------------
   // priority selection
   // ----------------------------------------------------------------
   // flags are level inputs owned by the peripherals, so a request raised again after
   // software clears its flag simply stays visible until the mask drops
   function automatic logic [VEC_W-1:0] pickVec(input logic [NSRC-1:0] req);
      logic [VEC_W-1:0] v;
      v = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) v = VEC_W'(i);
      end
      return v;
   endfunction : pickVec

   wire logic [NSRC-1:0]    qualReq   = srcFlag & srcEnable;
   wire logic               anyReq    = |qualReq;
   wire logic               maskBit   = flagsOut[FLAGS_MASK_BIT];
   wire logic               hwTake    = anyReq & ~maskBit;
   wire logic               trapTake  = trapOp | debugTrap;
   wire logic [VEC_W-1:0]   pickedVec = pickVec(qualReq);

   seq_state_t          state_r;
   seq_state_t          state_nxt;
   logic [2:0]          cnt_r;
   logic [2:0]          cnt_nxt;
   logic [VEC_W-1:0]    vec_r;
   logic [7:0]          vecHi_r;
   logic [ADDR_W-1:0]   fetch_r;
   logic                pendRd_r;
   logic                pendRd2_r;

   // ----------------------------------------------------------------
   // push byte selection and vector address
   // ----------------------------------------------------------------
   wire logic [7:0] pushByte = (cnt_r == 3'h0) ? pcOut[7:0] :
                               (cnt_r == 3'h1) ? pcOut[15:8] :
                               (cnt_r == 3'h2) ? idxLowOut :
                               (cnt_r == 3'h3) ? accOut : flagsOut;
   wire logic [ADDR_W-1:0] vecAddr = VEC_TOP - ADDR_W'({vec_r, 1'b0});
   wire logic lastPush = (cnt_r == FRAME_BYTES - 3'h1);
   wire logic lastFill = (cnt_r == 3'(QUEUE_BYTES - 1));
   wire logic [ADDR_W-1:0] spInc = spOut + ADDR_W'(1);
   wire logic [ADDR_W-1:0] spDec = spOut - ADDR_W'(1);
   // strobes are registered, so every read waits for its data before the next step uses it
   wire logic [2:0] popEnd  = FRAME_BYTES + RD_LAT - 3'h1;
   wire logic popLast    = (state_r == ST_POP) && (cnt_r == popEnd);
   wire logic popCapture = (state_r == ST_POP) && (cnt_r >= RD_LAT);
   wire logic vecLoRd    = (state_r == ST_VECLO) && (cnt_r == 3'h0);
   wire logic vecHiCap   = (state_r == ST_VECLO) && (cnt_r == RD_LAT - 3'h1);
   wire logic vecLoad    = (state_r == ST_VECLO) && (cnt_r == RD_LAT);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_RUN: begin
            if (instrDone && returnOp) begin
               state_nxt = ST_POP;
               cnt_nxt   = '0;
            end else if (instrDone && (hwTake || trapTake)) begin
               state_nxt = ST_PUSH;
               cnt_nxt   = '0;
            end
         end
         ST_PUSH: begin
            cnt_nxt = cnt_r + 3'h1;
            if (lastPush) state_nxt = ST_VECHI;
         end
         ST_VECHI: begin
            state_nxt = ST_VECLO;
            cnt_nxt   = '0;
         end
         ST_VECLO: begin
            cnt_nxt = cnt_r + 3'h1;
            if (vecLoad) begin
               state_nxt = ST_FILL;
               cnt_nxt   = '0;
            end
         end
         ST_FILL: begin
            cnt_nxt = cnt_r + 3'h1;
            if (lastFill) state_nxt = ST_RUN;
         end
         ST_POP: begin
            cnt_nxt = cnt_r + 3'h1;
            if (popLast) begin
               state_nxt = ST_FILL;
               cnt_nxt   = '0;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_RUN;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // vector is latched once per entry; a trap takes the top slot, hardware the winner
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         vec_r <= '0;
      end else if (state_r == ST_RUN && instrDone && !returnOp && (hwTake || trapTake)) begin
         vec_r <= trapTake ? '0 : VEC_W'(pickedVec + VEC_W'(1));
      end
   end

   // ----------------------------------------------------------------
   // cpu registers held by the sequencer
   // ----------------------------------------------------------------
   wire logic popRead = (state_r == ST_POP) && (cnt_r < FRAME_BYTES);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flagsOut <= FLAGS_RESET;
         spOut    <= SP_RESET;
         pcOut    <= PC_RESET;
         accOut   <= '0;
         idxLowOut <= '0;
      end else begin
         if (state_r == ST_RUN && instrDone) begin
            pcOut     <= nextPc;
            accOut    <= accIn;
            idxLowOut <= idxLowIn;
         end
         if (state_r == ST_RUN && flagsWrEn) flagsOut <= flagsWrData;
         if (state_r == ST_RUN && spWrEn) spOut <= spWrData;
         if (state_r == ST_PUSH) begin
            spOut <= spDec;
            if (lastPush) flagsOut[FLAGS_MASK_BIT] <= 1'b1;
         end
         if (vecLoad) pcOut <= {vecHi_r, memRdData};
         if (popRead) spOut <= spInc;
         if (popCapture) begin
            case (cnt_r)
               RD_LAT: flagsOut <= memRdData;
               RD_LAT + 3'h1: accOut <= memRdData;
               RD_LAT + 3'h2: idxLowOut <= memRdData;
               RD_LAT + 3'h3: pcOut[15:8] <= memRdData;
               default: pcOut[7:0] <= memRdData;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) vecHi_r <= '0;
      else if (vecHiCap) vecHi_r <= memRdData;
   end

   // ----------------------------------------------------------------
   // memory port and queue
   // ----------------------------------------------------------------
   wire logic fillRd = (state_r == ST_FILL);
   wire logic [ADDR_W-1:0] nxtAddr =
      (state_r == ST_PUSH)  ? spOut :
      (state_r == ST_VECHI) ? vecAddr :
      vecLoRd               ? vecAddr + ADDR_W'(1) :
      popRead               ? spInc :
      fillRd                ? pcOut + ADDR_W'(cnt_r) : '0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         memRd     <= 1'b0;
         memWr     <= 1'b0;
         memAddr   <= '0;
         memWrData <= '0;
         fetch_r   <= '0;
         pendRd_r  <= 1'b0;
         pendRd2_r <= 1'b0;
      end else begin
         memWr     <= (state_r == ST_PUSH);
         memRd     <= (state_r == ST_VECHI) || vecLoRd || popRead || fillRd;
         memAddr   <= nxtAddr;
         memWrData <= pushByte;
         fetch_r   <= nxtAddr;
         pendRd_r  <= fillRd;
         pendRd2_r <= pendRd_r;
      end
   end

   // fill bytes reach the queue one cycle after their read data stands
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         queueByte   <= '0;
         queueValid  <= 1'b0;
         busy        <= 1'b0;
         restoreDone <= 1'b0;
         servedVec   <= '0;
      end else begin
         queueValid  <= pendRd2_r;
         queueByte   <= memRdData;
         busy        <= (state_nxt != ST_RUN);
         restoreDone <= popLast;
         servedVec   <= vec_r;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence sqEntry;
      state_r == ST_RUN && instrDone && !returnOp && hwTake;
   endsequence

   sequence sqPushFrame;
      (state_r == ST_PUSH) [*5] ##1 state_r == ST_VECHI;
   endsequence

   AST_MASKED_NO_ENTRY: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_RUN && instrDone && maskBit && !trapTake && !returnOp) |=> state_r == ST_RUN)
      else $error("entry taken while masked");
   AST_RESET_MASK: assert property (@(posedge clk_sys) $rose(resetn) |-> flagsOut[FLAGS_MASK_BIT])
      else $error("mask clear after reset");
   AST_WAIT_BOUNDARY: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_RUN && !instrDone) |=> state_r == ST_RUN)
      else $error("entry before boundary");
   AST_MASK_AFTER_PUSH: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_PUSH && lastPush) |=> flagsOut[FLAGS_MASK_BIT])
      else $error("mask not set after stacking");
   AST_VEC_PRIORITY: assert property (@(posedge clk_sys) disable iff (!resetn)
      (sqEntry ##0 !trapTake) |=> vec_r == VEC_W'($past(pickedVec) + VEC_W'(1)))
      else $error("wrong vector latched");
   AST_FILL_THREE: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(state_r == ST_FILL) |-> (state_r == ST_FILL) [*3] ##1 state_r == ST_RUN)
      else $error("queue fill not three bytes");
   AST_FIRST_PCL: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_PUSH && cnt_r == 3'h0) |=> memWr && memWrData == $past(pcOut[7:0]))
      else $error("first byte not pcl");
   AST_SP_FRAME: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(state_r == ST_PUSH) |-> ##5 spOut == $past(spOut, 5) - ADDR_W'(5))
      else $error("sp not below flags byte");
   AST_POP_LENGTH: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(state_r == ST_POP) |-> ##7 state_r == ST_FILL)
      else $error("return pop length wrong");
   AST_ENTRY_STEPS: assert property (@(posedge clk_sys) disable iff (!resetn)
      sqEntry |=> sqPushFrame)
      else $error("hardware entry sequence wrong");
   AST_TRAP_STEPS: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_RUN && instrDone && !returnOp && trapTake) |=> sqPushFrame)
      else $error("trap entry sequence wrong");
   AST_SECOND_PCH: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_PUSH && cnt_r == 3'h1) |=> memWr && memWrData == $past(pcOut[15:8]))
      else $error("second byte not pch");
   AST_LAST_FLAGS: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_PUSH && lastPush) |=> memWr && memWrData == $past(flagsOut))
      else $error("last byte not flags");
   AST_PUSH_DOWN: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_PUSH) |=> memAddr == $past(spOut) && spOut == $past(spOut) - ADDR_W'(1))
      else $error("push not post-decrement");
   AST_VEC_HI_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == ST_VECHI) |=> memRd && memAddr == $past(vecAddr))
      else $error("vector high byte address wrong");
   AST_VEC_LO_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
      vecLoRd |=> memRd && memAddr == $past(vecAddr) + ADDR_W'(1))
      else $error("vector low byte address wrong");
   AST_FILL_FROM_PC: assert property (@(posedge clk_sys) disable iff (!resetn)
      fillRd |=> memRd && memAddr == $past(pcOut) + ADDR_W'($past(cnt_r)))
      else $error("fill address wrong");
   AST_POP_PREINC: assert property (@(posedge clk_sys) disable iff (!resetn)
      popRead |=> memRd && memAddr == $past(spOut) + ADDR_W'(1) && spOut == memAddr)
      else $error("pop not pre-increment");
   AST_FLAGS_RESTORE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (popCapture && cnt_r == RD_LAT) |=> flagsOut == $past(memRdData))
      else $error("flags not restored from stack");
endmodule : irq_entry_exit

// File: irq_src_model.sv
/*
 * peripheral interrupt sources: one status flag and one local enable each.
 * assumes events and flag clears come from the bench in the clk_sys domain.
 */
`timescale 1ns/100ps
module irq_src_model #(
   parameter int N = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic [N-1:0] evt,
   input  wire logic [N-1:0] clr,
   input  wire logic [N-1:0] enIn,
   output logic      [N-1:0] srcFlag,
   output logic      [N-1:0] srcEnable
);
   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   // an event in the same cycle as a clear wins if its enable is set; an event while enIn is low is dropped
   assign srcEnable = enIn;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         srcFlag <= '0;
      end else begin
         srcFlag <= (srcFlag & ~clr) | (evt & enIn);
      end
   end
endmodule : irq_src_model

// File: tb.sv
/*
 * self-checking bench for the interrupt entry and return sequencer.
 * assumes a byte memory answering one cycle after memRd, modelled here.
 */
`timescale 1ns/100ps
module tb;
   import irq_seq_pkg::*;
   localparam int NS = 4;
   logic clk_sys = 1'b0, resetn = 1'b0, instrDone = 1'b0, trapOp = 1'b0, debugTrap = 1'b0, returnOp = 1'b0;
   logic flagsWrEn = 1'b0, spWrEn = 1'b0, busy, memRd, memWr, restoreDone, queueValid;
   logic [15:0] nextPc = 16'h0000, spWrData = 16'h0000, memAddr, spOut, pcOut;
   logic [7:0] accIn = 8'ha1, idxLowIn = 8'hb2, flagsWrData = 8'h00, memRdData = 8'h00;
   logic [7:0] memWrData, flagsOut, accOut, idxLowOut, queueByte;
   logic [NS-1:0] evt = '0, clr = '0, enIn = '0, srcFlag, srcEnable;
   logic [VEC_W-1:0] servedVec;
   logic [7:0] mem [0:65535];
   logic [7:0] qSeen [$];
   int badCount = 0, nChecks = 0;
   int restoreSeen = 0;

   always #2.5 clk_sys = ~clk_sys;
   irq_src_model #(.N(NS)) srcs (.clk_sys(clk_sys), .resetn(resetn), .evt(evt), .clr(clr), .enIn(enIn),
      .srcFlag(srcFlag), .srcEnable(srcEnable));
   irq_entry_exit #(.NSRC(NS)) dut (.clk_sys(clk_sys), .resetn(resetn), .srcFlag(srcFlag),
      .srcEnable(srcEnable), .instrDone(instrDone), .nextPc(nextPc), .accIn(accIn), .idxLowIn(idxLowIn),
      .trapOp(trapOp), .debugTrap(debugTrap), .returnOp(returnOp), .flagsWrEn(flagsWrEn),
      .flagsWrData(flagsWrData), .spWrEn(spWrEn), .spWrData(spWrData), .memRdData(memRdData), .busy(busy),
      .memRd(memRd), .memWr(memWr), .memAddr(memAddr), .memWrData(memWrData), .flagsOut(flagsOut),
      .spOut(spOut), .pcOut(pcOut), .accOut(accOut), .idxLowOut(idxLowOut), .restoreDone(restoreDone),
      .servedVec(servedVec), .queueByte(queueByte), .queueValid(queueValid));

   // ------------------------------------------------------------
   // memory model
   // ------------------------------------------------------------
   // read data is not held after its cycle: inverted so stale data is never mistaken for fresh
   always @(posedge clk_sys) begin
      memRdData <= memRd ? mem[memAddr] : ~memRdData;
      if (memWr) mem[memAddr] <= memWrData;
      if (queueValid) qSeen.push_back(queueByte);
      if (restoreDone) restoreSeen++;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one instruction boundary, then wait for the sequence and the queue refill to finish
   task automatic bound(input logic [15:0] pc, input logic ret, input logic tr, input logic dbg,
                        output logic sawBusy);
      int i;
      qSeen.delete();
      @(posedge clk_sys);
      instrDone <= 1'b1;
      nextPc <= pc;
      returnOp <= ret;
      trapOp <= tr;
      debugTrap <= dbg;
      @(posedge clk_sys);
      instrDone <= 1'b0;
      returnOp <= 1'b0;
      trapOp <= 1'b0;
      debugTrap <= 1'b0;
      #1;
      sawBusy = busy;
      i = 0;
      while (busy !== 1'b0 && i < 40) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      if (i == 40) begin
         badCount++;
         stop_test();
      end
      repeat (4) @(posedge clk_sys);
   endtask : bound

   task automatic load_regs(input logic [7:0] f, input logic [15:0] sp);
      @(posedge clk_sys);
      flagsWrEn <= 1'b1;
      flagsWrData <= f;
      spWrEn <= 1'b1;
      spWrData <= sp;
      @(posedge clk_sys);
      flagsWrEn <= 1'b0;
      spWrEn <= 1'b0;
   endtask : load_regs

   task automatic chk_queue(input logic [15:0] a);
      chk("queue count", 16'h0003, 16'(qSeen.size()));
      for (int k = 0; k < 3 && k < qSeen.size(); k++) chk("queue byte", {8'h00, mem[a + k]}, {8'h00, qSeen[k]});
   endtask : chk_queue

   task automatic t_masked();
      logic b;
      @(posedge clk_sys);
      enIn <= 4'b0010;
      evt <= 4'b0010;
      @(posedge clk_sys);
      evt <= 4'b0000;
      bound(16'h0100, 1'b0, 1'b0, 1'b0, b);
      chk("busy while masked", 16'h0000, {15'h0, b});
      enIn <= 4'b0000;
      load_regs(8'h00, 16'h0080);
      bound(16'h0100, 1'b0, 1'b0, 1'b0, b);
      chk("busy with enable low", 16'h0000, {15'h0, b});
      $display("t_masked done");
   endtask : t_masked

   task automatic t_entry();
      logic b;
      enIn <= 4'b0110;
      evt <= 4'b0100;
      repeat (5) @(posedge clk_sys);
      evt <= 4'b0000;
      #1;
      chk("busy without boundary", 16'h0000, {15'h0, busy});
      bound(16'h1234, 1'b0, 1'b0, 1'b0, b);
      chk("busy", 16'h0001, {15'h0, b});
      chk("stack pcl", 16'h0034, {8'h00, mem[16'h0080]});
      chk("stack pch", 16'h0012, {8'h00, mem[16'h007f]});
      chk("stack x", 16'h00b2, {8'h00, mem[16'h007e]});
      chk("stack a", 16'h00a1, {8'h00, mem[16'h007d]});
      chk("stack flags", 16'h0000, {8'h00, mem[16'h007c]});
      chk("sp after entry", 16'h007b, spOut);
      chk("mask after entry", 16'h0001, {15'h0, flagsOut[FLAGS_MASK_BIT]});
      chk("vector slot", 16'h0002, {10'h0, servedVec});
      chk("pc from vector", 16'h4010, pcOut);
      chk_queue(16'h4010);
      $display("t_entry done");
   endtask : t_entry

   task automatic t_return();
      logic b;
      int r0;
      @(posedge clk_sys);
      accIn <= 8'h3c;
      idxLowIn <= 8'hc3;
      clr <= 4'b0010;
      @(posedge clk_sys);
      clr <= 4'b0000;
      evt <= 4'b0010;
      @(posedge clk_sys);
      evt <= 4'b0000;
      r0 = restoreSeen;
      bound(16'h4013, 1'b1, 1'b0, 1'b0, b);
      chk("restore pulses", 16'h0001, 16'(restoreSeen - r0));
      chk("flags restored", 16'h0000, {8'h00, flagsOut});
      chk("a restored", 16'h00a1, {8'h00, accOut});
      chk("x restored", 16'h00b2, {8'h00, idxLowOut});
      chk("pc restored", 16'h1234, pcOut);
      chk("sp restored", 16'h0080, spOut);
      chk_queue(16'h1234);
      bound(16'h1234, 1'b0, 1'b0, 1'b0, b);
      chk("re-raised source served first", 16'h0002, {10'h0, servedVec});
      $display("t_return done");
   endtask : t_return

   // software clears the flag, then the mask, inside the routine so a lower source nests
   task automatic t_nest();
      logic b;
      @(posedge clk_sys);
      clr <= 4'b0010;
      @(posedge clk_sys);
      clr <= 4'b0000;
      load_regs(8'h00, 16'h007b);
      bound(16'h4020, 1'b0, 1'b0, 1'b0, b);
      chk("nested entry", 16'h0001, {15'h0, b});
      chk("nested slot", 16'h0003, {10'h0, servedVec});
      chk("nested pc", 16'h6020, pcOut);
      chk("nested sp", 16'h0076, spOut);
      chk_queue(16'h6020);
      $display("t_nest done");
   endtask : t_nest

   task automatic t_trap(input logic tr, input logic dbg, input logic [15:0] spExp);
      logic b;
      bound(16'h2000, 1'b0, tr, dbg, b);
      chk("trap busy", 16'h0001, {15'h0, b});
      chk("trap slot", 16'h0000, {10'h0, servedVec});
      chk("trap pc", 16'h5000, pcOut);
      chk("trap sp", spExp, spOut);
      $display("t_trap done");
   endtask : t_trap

   initial begin
      for (int k = 0; k < 65536; k++) mem[k] = k[7:0] ^ 8'h5a;
      mem[16'hfffa] = 8'h40;
      mem[16'hfffb] = 8'h10;
      mem[16'hfff8] = 8'h60;
      mem[16'hfff9] = 8'h20;
      mem[16'hfffe] = 8'h50;
      mem[16'hffff] = 8'h00;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("flags at reset", {8'h00, FLAGS_RESET}, {8'h00, flagsOut});
      chk("sp at reset", SP_RESET, spOut);
      t_masked();
      t_entry();
      t_return();
      t_nest();
      t_trap(1'b0, 1'b1, 16'h0071);
      t_trap(1'b1, 1'b0, 16'h006c);
      stop_test();
   end
endmodule : tb
